// ===== logic/tza_pkg.sv
// Shared constants for the two-zone thermal alarm and conversion controller.
// Assumes a 100 MHz core clock and a standard two-wire serial host outside.
package tza_pkg;
  // Core clock and conversion timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CONV_TIME_MS = 160;
  localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int CONV_CNT_W = 24;

  // Register pointer codes
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // Control byte fields
  localparam int CFG_FLAG = 7;
  localparam int CFG_MASK = 6;
  localparam int CFG_ZONE = 5;
  localparam int CFG_FQ_HI = 4;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_POL = 2;
  localparam int CFG_MODE = 1;
  localparam int CFG_SHDN = 0;
  localparam logic [6:0] CFG_RESET = 7'h00;

  // Temperature word layout: nine bits in the top of a 16-bit word
  localparam int TW_MSB = 15;
  localparam int TW_LSB = 7;
  localparam logic [6:0] TW_PAD = 7'h00;
  localparam logic [8:0] TEMP_RESET = 9'h000;
  localparam logic [8:0] LOWER_RESET = 9'h096;
  localparam logic [8:0] UPPER_RESET = 9'h0a0;

  // Serial framing
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] ADDR_HI_DEF = 4'h9;

  // Fault queue depths for codes 00, 01, 10, 11
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;

  typedef enum {L_IDLE, L_ADDR, L_PTR, L_WDATA, L_RDATA} tza_link_state_t;
endpackage

// ===== logic/tza_alarm_ctrl.sv
// Alarm and conversion control for a two-zone temperature supervisor,
// with its two-wire serial slave running on the bus clock.
// Assumes the host owns the bus clock and that sensor samples are ready
// in the core clock domain whenever a conversion completes.
`timescale 1ns/1ps

module tza_alarm_ctrl
  import tza_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter logic [3:0] ADDR_HI = ADDR_HI_DEF
)
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Serial bus
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] addr_pins,
  // Alert pin, open drain
  output logic alert_o,
  output logic alert_oe,
  // Sensor samples
  input wire logic [8:0] local_temp,
  input wire logic [8:0] remote_temp,
  // Status
  output logic conv_halted
);
  if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << CONV_CNT_W))
  begin : g_bad_conv
    $error("CONV_CYCLES out of range for counter");
  end

  function automatic logic [2:0] fq_need(input logic [1:0] code);
    unique case (code)
      2'b00: fq_need = FQ_DEPTH_0;
      2'b01: fq_need = FQ_DEPTH_1;
      2'b10: fq_need = FQ_DEPTH_2;
      2'b11: fq_need = FQ_DEPTH_3;
    endcase
  endfunction

  // Core-side state, read by the link only while the converter is halted
  logic [8:0] temp_reg;
  logic [8:0] lower_threshold_reg;
  logic [8:0] upper_threshold_reg;
  logic [6:0] cfg_reg;
  logic alarm_flag_reg;
  logic pending_reg;
  logic seek_over_reg;
  logic [2:0] fault_cnt_reg;
  logic halted_reg;
  logic [CONV_CNT_W-1:0] conv_cnt_reg;
  logic alert_oe_reg;

  // Link-side state
  logic start_tgl;
  logic stop_tgl;
  logic start_ack_reg;
  tza_link_state_t lstate_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] sh_reg;
  logic [1:0] ptr_reg;
  logic byte_idx_reg;
  logic rd_reg;
  logic ack_req_reg;
  logic [7:0] whi_reg;
  logic [15:0] wr_data_reg;
  logic [1:0] wr_ptr_reg;
  logic wr_tgl_reg;
  logic addr_tgl_reg;
  logic rdcfg_tgl_reg;
  logic sda_oe_reg;
  logic [2:0] apin_s1_reg;
  logic [2:0] apin_s2_reg;

  // Start and stop seen as data edges while the bus clock is high
  always_ff @(negedge sda_i or posedge reset)
  begin
    if (reset)
      start_tgl <= 1'b0;
    else if (scl_clk)
      start_tgl <= ~start_tgl;
  end

  always_ff @(posedge sda_i or posedge reset)
  begin
    if (reset)
      stop_tgl <= 1'b0;
    else if (scl_clk)
      stop_tgl <= ~stop_tgl;
  end

  // Address pins are static straps but still pass two flops
  always_ff @(posedge scl_clk or posedge reset)
  begin
    if (reset)
    begin
      apin_s1_reg <= 3'h0;
      apin_s2_reg <= 3'h0;
    end
    else
    begin
      apin_s1_reg <= addr_pins;
      apin_s2_reg <= apin_s1_reg;
    end
  end

  logic [7:0] byte_in;
  logic [7:0] cfg_byte;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  assign byte_in = {sh_reg, sda_i};
  assign cfg_byte = {alarm_flag_reg, cfg_reg};
  always_comb
  begin
    unique case (ptr_reg)
      PTR_TEMP: rd_word = {temp_reg, TW_PAD};
      PTR_CFG: rd_word = {cfg_byte, 8'h00};
      PTR_LOWER: rd_word = {lower_threshold_reg, TW_PAD};
      PTR_UPPER: rd_word = {upper_threshold_reg, TW_PAD};
    endcase
  end
  assign rd_byte = (ptr_reg == PTR_CFG || !byte_idx_reg) ? rd_word[15:8] : rd_word[7:0];

  // Serial slave: bits sampled on the rising bus clock edge
  always_ff @(posedge scl_clk or posedge reset)
  begin
    if (reset)
    begin
      lstate_reg <= L_IDLE;
      start_ack_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 7'h00;
      ptr_reg <= PTR_TEMP;
      byte_idx_reg <= 1'b0;
      rd_reg <= 1'b0;
      ack_req_reg <= 1'b0;
      whi_reg <= 8'h00;
      wr_data_reg <= 16'h0000;
      wr_ptr_reg <= PTR_TEMP;
      wr_tgl_reg <= 1'b0;
      addr_tgl_reg <= 1'b0;
      rdcfg_tgl_reg <= 1'b0;
    end
    else if (start_tgl != start_ack_reg)
    begin
      start_ack_reg <= start_tgl;
      lstate_reg <= L_ADDR;
      sh_reg <= {6'h00, sda_i};
      bit_cnt_reg <= 4'h1;
      ack_req_reg <= 1'b0;
    end
    else if (lstate_reg != L_IDLE)
    begin
      sh_reg <= byte_in[6:0];
      bit_cnt_reg <= (bit_cnt_reg == BIT_ACK) ? 4'h0 : bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == BIT_LAST)
      begin
        unique case (lstate_reg)
          L_ADDR:
            if (byte_in[7:1] == {ADDR_HI, apin_s2_reg})
            begin
              ack_req_reg <= 1'b1;
              addr_tgl_reg <= ~addr_tgl_reg;
              rd_reg <= byte_in[0];
            end
            else
              lstate_reg <= L_IDLE;
          L_PTR:
          begin
            ptr_reg <= byte_in[1:0];
            byte_idx_reg <= 1'b0;
            ack_req_reg <= 1'b1;
          end
          L_WDATA:
          begin
            ack_req_reg <= 1'b1;
            byte_idx_reg <= ~byte_idx_reg;
            whi_reg <= byte_in;
            // Control byte commits at once, thresholds after both bytes
            if (ptr_reg == PTR_CFG || byte_idx_reg)
            begin
              wr_data_reg <= (ptr_reg == PTR_CFG) ? {byte_in, 8'h00} : {whi_reg, byte_in};
              wr_ptr_reg <= ptr_reg;
              wr_tgl_reg <= ~wr_tgl_reg;
            end
          end
          L_RDATA:
          begin
            ack_req_reg <= 1'b0;
            // Clear only after the flag bit has gone out on the wire
            if (ptr_reg == PTR_CFG && !byte_idx_reg)
              rdcfg_tgl_reg <= ~rdcfg_tgl_reg;
          end
        endcase
      end
      else if (bit_cnt_reg == BIT_ACK)
      begin
        ack_req_reg <= 1'b0;
        unique case (lstate_reg)
          L_ADDR:
          begin
            lstate_reg <= rd_reg ? L_RDATA : L_PTR;
            byte_idx_reg <= 1'b0;
          end
          L_PTR:
            lstate_reg <= L_WDATA;
          L_WDATA:
            lstate_reg <= L_WDATA;
          L_RDATA:
          begin
            byte_idx_reg <= ~byte_idx_reg;
            if (sda_i)
              lstate_reg <= L_IDLE; // Host declined further bytes
          end
        endcase
      end
    end
  end

  // Data line driven on the falling bus clock edge, low only
  always_ff @(negedge scl_clk or posedge reset)
  begin
    if (reset)
      sda_oe_reg <= 1'b0;
    else
      sda_oe_reg <= ack_req_reg || (lstate_reg == L_RDATA && bit_cnt_reg < BIT_ACK
        && !rd_byte[3'(BIT_LAST - bit_cnt_reg)]);
  end
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_reg;

  // Event toggles from the link cross by two flops plus an edge stage
  logic [2:0] addr_s_reg;
  logic [2:0] stop_s_reg;
  logic [2:0] wr_s_reg;
  logic [2:0] rdc_s_reg;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      addr_s_reg <= 3'h0;
      stop_s_reg <= 3'h0;
      wr_s_reg <= 3'h0;
      rdc_s_reg <= 3'h0;
    end
    else
    begin
      addr_s_reg <= {addr_s_reg[1:0], addr_tgl_reg};
      stop_s_reg <= {stop_s_reg[1:0], stop_tgl};
      wr_s_reg <= {wr_s_reg[1:0], wr_tgl_reg};
      rdc_s_reg <= {rdc_s_reg[1:0], rdcfg_tgl_reg};
    end
  end
  logic addr_evt;
  logic stop_evt;
  logic wr_evt;
  logic rd_evt;
  assign addr_evt = addr_s_reg[2] ^ addr_s_reg[1];
  assign stop_evt = stop_s_reg[2] ^ stop_s_reg[1];
  assign wr_evt = wr_s_reg[2] ^ wr_s_reg[1];
  assign rd_evt = rdc_s_reg[2] ^ rdc_s_reg[1];

  // Halt while the host talks to us; a stop ending the access wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      halted_reg <= 1'b0;
    else if (stop_evt)
      halted_reg <= 1'b0;
    else if (addr_evt)
      halted_reg <= 1'b1;
  end
  assign conv_halted = halted_reg;

  // Control byte and thresholds, written only through the link
  logic cfg_wr;
  logic [6:0] cfg_next;
  assign cfg_wr = wr_evt && wr_ptr_reg == PTR_CFG;
  assign cfg_next = wr_data_reg[14:8];
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cfg_reg <= CFG_RESET;
      lower_threshold_reg <= LOWER_RESET;
      upper_threshold_reg <= UPPER_RESET;
    end
    else if (wr_evt)
    begin
      unique case (wr_ptr_reg)
        PTR_CFG: cfg_reg <= cfg_next;
        PTR_LOWER: lower_threshold_reg <= wr_data_reg[TW_MSB:TW_LSB];
        PTR_UPPER: upper_threshold_reg <= wr_data_reg[TW_MSB:TW_LSB];
        PTR_TEMP: cfg_reg <= cfg_reg; // Result is read only
      endcase
    end
  end

  // Free-running conversion, restarted from zero by any halt
  logic conv_done;
  assign conv_done = !halted_reg && !cfg_reg[CFG_SHDN]
    && conv_cnt_reg == CONV_CNT_W'(CONV_CYCLES - 1);
  always_ff @(posedge ref_clk)
  begin
    if (reset || addr_evt || halted_reg || cfg_reg[CFG_SHDN] || conv_done)
      conv_cnt_reg <= '0;
    else
      conv_cnt_reg <= conv_cnt_reg + 1'b1;
  end

  // Result register takes only whole conversions of the selected zone
  logic [8:0] temp_next;
  assign temp_next = cfg_reg[CFG_ZONE] ? remote_temp : local_temp;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      temp_reg <= TEMP_RESET;
    else if (conv_done)
      temp_reg <= temp_next;
  end

  // Fault queue and direction of the awaited event
  logic beyond;
  logic alarm_evt;
  logic rearm;
  assign beyond = seek_over_reg ? ($signed(temp_next) > $signed(upper_threshold_reg))
    : ($signed(temp_next) < $signed(lower_threshold_reg));
  assign alarm_evt = conv_done && beyond
    && (fault_cnt_reg + 3'h1) == fq_need(cfg_reg[CFG_FQ_HI:CFG_FQ_LO]);
  assign rearm = cfg_wr && !cfg_reg[CFG_MODE] && cfg_next[CFG_MODE];
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      seek_over_reg <= 1'b1;
      fault_cnt_reg <= 3'h0;
    end
    else if (rearm)
    begin
      seek_over_reg <= 1'b1;
      fault_cnt_reg <= 3'h0;
    end
    else if (alarm_evt)
    begin
      seek_over_reg <= ~seek_over_reg;
      fault_cnt_reg <= 3'h0;
    end
    else if (conv_done)
      fault_cnt_reg <= beyond ? fault_cnt_reg + 3'h1 : 3'h0;
  end

  // Flag and pending request: a new event outranks a clearing read
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      alarm_flag_reg <= 1'b0;
      pending_reg <= 1'b0;
    end
    else if (alarm_evt)
    begin
      alarm_flag_reg <= 1'b1;
      pending_reg <= 1'b1;
    end
    else if (rd_evt)
    begin
      alarm_flag_reg <= 1'b0;
      pending_reg <= 1'b0;
    end
  end

  // Open-drain alert; polarity decides whether pulling low means active
  logic alert_active;
  assign alert_active = cfg_reg[CFG_MODE] ? pending_reg : !seek_over_reg;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      alert_oe_reg <= 1'b0;
    else
      alert_oe_reg <= !cfg_reg[CFG_MASK] && (alert_active ^ cfg_reg[CFG_POL]);
  end
  assign alert_o = 1'b0;
  assign alert_oe = alert_oe_reg;

  a_halt_on_addr: assert property (@(posedge ref_clk) disable iff (reset)
    addr_evt && !stop_evt |=> halted_reg && conv_cnt_reg == '0)
    else $error("conversion not halted on address");
  a_halt_holds: assert property (@(posedge ref_clk) disable iff (reset)
    halted_reg && !stop_evt |=> halted_reg && !conv_done)
    else $error("halted conversion resumed early");
  a_no_partial: assert property (@(posedge ref_clk) disable iff (reset)
    temp_reg != $past(temp_reg) |-> $past(conv_done))
    else $error("result changed outside a conversion end");
  a_zone_restart: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_wr && cfg_next[CFG_ZONE] != cfg_reg[CFG_ZONE] |=> conv_cnt_reg == '0)
    else $error("zone change did not restart conversion");
  a_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
    rd_evt && !alarm_evt |=> !alarm_flag_reg && !pending_reg)
    else $error("control read did not clear flag");
  a_mode_rearm: assert property (@(posedge ref_clk) disable iff (reset)
    rearm |=> seek_over_reg && fault_cnt_reg == 3'h0)
    else $error("mode change did not re-arm");
  a_mask_hiz: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_reg[CFG_MASK] |=> !alert_oe_reg)
    else $error("alert driven while masked");
  a_event_alt: assert property (@(posedge ref_clk) disable iff (reset)
    alarm_evt && !rearm |=> seek_over_reg != $past(seek_over_reg))
    else $error("event direction did not alternate");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (reset)
    alarm_evt |=> alarm_flag_reg && pending_reg)
    else $error("event did not set flag");
  a_queue_depth: assert property (@(posedge ref_clk) disable iff (reset)
    alarm_evt |-> fault_cnt_reg == fq_need(cfg_reg[CFG_FQ_HI:CFG_FQ_LO]) - 3'h1)
    else $error("alarm before fault queue filled");
  a_conv_bound: assert property (@(posedge ref_clk) disable iff (reset)
    conv_cnt_reg <= CONV_CNT_W'(CONV_CYCLES - 1))
    else $error("conversion counter overran");
endmodule

// ===== tb/tza_host.sv
// Two-wire bus host model for the thermal alarm controller bench.
// Assumes the bench resolves the data wire with a pull-up from all drivers.
`timescale 1ns/1ps
module tza_host
(
  // Bus clock, stands high between frames
  output logic scl,
  // Data wire: drive enable high pulls it low
  output logic sda_pull,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // One bit, data moves only while the clock is low; 64 ns per bit
  task automatic bit_io(input logic b, output logic s);
    sda_pull = !b;
    #16 scl = 1'b1;
    #16 s = sda;
    #16 scl = 1'b0;
    #16;
  endtask

  // Start from idle, or a repeated start from mid-frame
  task automatic start();
    if (!scl)
    begin
      sda_pull = 1'b0;
      #16 scl = 1'b1;
      #16;
    end
    sda_pull = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask

  // Stop leaves the clock high and the wire released
  task automatic stop();
    sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #16;
  endtask

  // Eight bits then the acknowledge bit; send 8'hff to read
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the thermal alarm and conversion controller.
// Assumes the host model drives the bus clock only inside frames.
`timescale 1ns/1ps
module tb;
  import tza_pkg::*;
  localparam int CONV = 40;
  logic ref_clk = 1'b0;
  logic reset;
  logic [2:0] addr_pins = 3'h0;
  logic [8:0] local_temp = 9'h000;
  logic [8:0] remote_temp = 9'h000;
  logic [31:0] seed = 32'h0000_f1c1;
  int n_mismatch = 0;
  int n_tests = 0;
  logic scl_clk, host_pull, sda_o, sda_oe, alert_o, alert_oe, conv_halted;
  wire logic sda;

  // Open-drain data wire with pull-up
  assign sda = !(host_pull | sda_oe);

  tza_alarm_ctrl #(.CONV_CYCLES(CONV), .ADDR_HI(ADDR_HI_DEF)) tza_alarm_ctrl_inst (
    .ref_clk(ref_clk), .reset(reset), .scl_clk(scl_clk), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_pins(addr_pins), .alert_o(alert_o), .alert_oe(alert_oe),
    .local_temp(local_temp), .remote_temp(remote_temp), .conv_halted(conv_halted));
  tza_host tza_host_inst (.scl(scl_clk), .sda_pull(host_pull), .sda(sda));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Positive samples keep clear of both test thresholds
  function automatic logic [8:0] rnd_temp();
    seed = lfsr(seed);
    return {1'b0, seed[7:0]} % 9'd200;
  endfunction
  function automatic logic [15:0] tword(input logic [8:0] t);
    return {t, TW_PAD};
  endfunction
  function automatic int fq_depth(input logic [1:0] q);
    case (q)
      2'h0: return int'(FQ_DEPTH_0);
      2'h1: return int'(FQ_DEPTH_1);
      2'h2: return int'(FQ_DEPTH_2);
      default: return int'(FQ_DEPTH_3);
    endcase
  endfunction

  task automatic chkv(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Byte written by the host, slave must pull the acknowledge low
  task automatic wb(input logic [7:0] b);
    logic [7:0] r;
    logic a;
    tza_host_inst.xfer(b, 1'b1, r, a);
    chkb("slave ack", 1'b0, a);
  endtask
  task automatic open_w(input logic [1:0] p);
    @(posedge ref_clk);
    #1;
    tza_host_inst.start();
    wb({ADDR_HI_DEF, addr_pins, 1'b0});
    wb({6'h00, p});
  endtask
  task automatic wr_cfg(input logic [7:0] c);
    open_w(PTR_CFG);
    wb(c);
    tza_host_inst.stop();
  endtask
  task automatic wr_thr(input logic [1:0] p, input logic [15:0] w);
    open_w(p);
    wb(w[15:8]);
    wb(w[7:0]);
    tza_host_inst.stop();
  endtask
  // Repeated start, read one or two bytes, last one refused
  task automatic read_tail(input logic two, output logic [15:0] v);
    logic [7:0] r;
    logic a;
    tza_host_inst.start();
    wb({ADDR_HI_DEF, addr_pins, 1'b1});
    tza_host_inst.xfer(8'hff, !two, r, a);
    v = {8'h00, r};
    if (two)
    begin
      tza_host_inst.xfer(8'hff, 1'b1, r, a);
      v = {v[7:0], r};
    end
    tza_host_inst.stop();
  endtask
  task automatic rd(input logic [1:0] p, input logic two, output logic [15:0] v);
    open_w(p);
    read_tail(two, v);
  endtask
  task automatic wait_alert(input int lim, output int t);
    t = 0;
    while (alert_oe !== 1'b1 && t < lim)
    begin
      @(posedge ref_clk);
      t++;
    end
  endtask

  // Watchdog, well beyond the expected run
  initial
  begin
    #1_000_000;
    n_mismatch++;
    test_done();
  end

  initial
  begin
    logic [15:0] v;
    logic [7:0] r;
    logic [7:0] c;
    logic [8:0] ta;
    logic a;
    int t;
    int d;
    // Raised in a process so the link's asynchronously reset flops see an edge
    reset = 1'b1;
    seed = lfsr(seed);
    addr_pins = seed[2:0];
    local_temp = rnd_temp();
    repeat (2) @(posedge ref_clk);
    #1 reset = 1'b0;
    chkb("halt at reset", 1'b0, conv_halted);
    rd(PTR_CFG, 1'b0, v);
    chkv("cfg reset", 16'h0000, v);
    rd(PTR_LOWER, 1'b1, v);
    chkv("lower reset", tword(LOWER_RESET), v);
    rd(PTR_UPPER, 1'b1, v);
    chkv("upper reset", tword(UPPER_RESET), v);
    // Foreign address must neither answer nor halt
    @(posedge ref_clk);
    #1;
    tza_host_inst.start();
    tza_host_inst.xfer({ADDR_HI_DEF, addr_pins ^ 3'h1, 1'b0}, 1'b1, r, a);
    chkb("foreign ack", 1'b1, a);
    repeat (5) @(posedge ref_clk);
    chkb("foreign halt", 1'b0, conv_halted);
    tza_host_inst.stop();
    // Identification: over event, clear, under event, over again
    wr_cfg(8'h02);
    wr_thr(PTR_UPPER, 16'hc880);
    wr_thr(PTR_LOWER, 16'hc880);
    wait_alert(CONV + 20, t);
    chkb("first alert", 1'b1, alert_oe);
    rd(PTR_CFG, 1'b0, v);
    chkv("cfg alarmed", 16'h0082, v);
    repeat (8) @(posedge ref_clk);
    chkb("alert cleared", 1'b0, alert_oe);
    rd(PTR_CFG, 1'b0, v);
    chkv("cfg cleared", 16'h0002, v);
    wr_thr(PTR_UPPER, 16'h7f80);
    wr_thr(PTR_LOWER, 16'h7f80);
    wait_alert(CONV + 20, t);
    chkb("under alert", 1'b1, alert_oe);
    rd(PTR_CFG, 1'b0, v);
    chkv("cfg under", 16'h0082, v);
    wr_thr(PTR_UPPER, 16'hc880);
    wr_thr(PTR_LOWER, 16'hc880);
    wait_alert(CONV + 20, t);
    chkb("over again", 1'b1, alert_oe);
    rd(PTR_CFG, 1'b0, v);
    // Zone switch with every queue depth; the mode change re-arms the comparator for over
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      #1;
      local_temp = rnd_temp();
      remote_temp = rnd_temp();
      c = {2'b00, k[0], k[1:0], 3'b000};
      wr_cfg(8'h42);
      rd(PTR_CFG, 1'b0, v);
      chkv("cfg before switch", 16'h0042, v);
      wr_cfg(c | 8'h40);
      repeat (4) @(posedge ref_clk);
      chkb("masked alert", 1'b0, alert_oe);
      wr_cfg(c | 8'h02);
      wait_alert(6 * CONV + 40, t);
      d = fq_depth(k[1:0]);
      chkb("alarm delay", 1'b1, t > (d - 1) * CONV && t <= d * CONV + 12);
      rd(PTR_CFG, 1'b0, v);
      chkv("cfg after alarm", {8'h00, c | 8'h82}, v);
      rd(PTR_TEMP, 1'b1, v);
      chkv("zone temp", tword(k[0] ? remote_temp : local_temp), v);
    end
    // Halt on own address keeps the old result until the access ends
    ta = rnd_temp();
    local_temp = ta;
    wr_cfg(8'h02);
    repeat (CONV + 10) @(posedge ref_clk);
    rd(PTR_TEMP, 1'b1, v);
    chkv("local temp", tword(ta), v);
    @(posedge ref_clk);
    #1;
    tza_host_inst.start();
    wb({ADDR_HI_DEF, addr_pins, 1'b0});
    repeat (5) @(posedge ref_clk);
    chkb("halt on address", 1'b1, conv_halted);
    #1 local_temp = ta + 9'h001;
    repeat (3 * CONV) @(posedge ref_clk);
    chkb("halt held", 1'b1, conv_halted);
    wb({6'h00, PTR_TEMP});
    read_tail(1'b1, v);
    chkv("temp during halt", tword(ta), v);
    repeat (8) @(posedge ref_clk);
    chkb("halt released", 1'b0, conv_halted);
    repeat (CONV + 10) @(posedge ref_clk);
    rd(PTR_TEMP, 1'b1, v);
    chkv("temp after resume", tword(ta + 9'h001), v);
    // Shutdown stops conversions, so the result stays frozen
    wr_cfg(8'h03);
    local_temp = ta;
    repeat (CONV + 10) @(posedge ref_clk);
    rd(PTR_TEMP, 1'b1, v);
    chkv("temp in shutdown", tword(ta + 9'h001), v);
    chkb("open drain levels", 1'b0, alert_o | sda_o);
    test_done();
  end
endmodule
